// file: common/dsl_pkg.sv
// Shared constants and types for the shutdown-lockout serial converter control
package dsl_pkg;

  localparam int DSL_NUM_CH     = 4;
  localparam int DSL_DATA_W     = 12;
  localparam int DSL_WORD_W     = 16;
  localparam int DSL_FIFO_DEPTH = 16;

  // Power-up values
  localparam logic [11:0] DSL_ZERO_CODE = 12'h000;
  localparam logic [15:0] DSL_SHIFT_RST = 16'h0000;
  localparam logic        DSL_UPO_RST   = 1'h0;

  // Control-bit pairs that load one input register
  localparam logic [1:0] DSL_CTRL_LOAD     = 2'h1;
  localparam logic [1:0] DSL_CTRL_LOAD_UPD = 2'h3;

  // Full address/control codes
  localparam logic [3:0] DSL_OP_NOP       = 4'h0;
  localparam logic [3:0] DSL_OP_UPO_LO    = 4'h2;
  localparam logic [3:0] DSL_OP_UPD_ALL   = 4'h4;
  localparam logic [3:0] DSL_OP_UPO_HI    = 4'h6;
  localparam logic [3:0] DSL_OP_LOAD_ALL  = 4'h8;
  localparam logic [3:0] DSL_OP_MODE_FALL = 4'hA;
  localparam logic [3:0] DSL_OP_SHUTDOWN  = 4'hC;
  localparam logic [3:0] DSL_OP_MODE_RISE = 4'hE;

  // Shift edges needed before the chain output carries input bits
  localparam logic [4:0] DSL_LAG_RUN = 5'h10;

  typedef enum logic {
    DSL_MODE_FALL = 1'b0,
    DSL_MODE_RISE = 1'b1
  } dsl_mode_t;

  localparam dsl_mode_t DSL_MODE_RST = DSL_MODE_FALL;

  typedef logic [DSL_DATA_W-1:0] dsl_code_t;
  typedef dsl_code_t [DSL_NUM_CH-1:0] dsl_bank_t;

  typedef struct packed {
    logic      addr_bit_hi;
    logic      addr_bit_lo;
    logic      ctrl_bit_hi;
    logic      ctrl_bit_lo;
    dsl_code_t data;
  } dsl_cmd_t;

  typedef struct packed {
    logic      cs_prev;
    logic      pend;
    dsl_cmd_t  word;
    dsl_bank_t in_reg;
    dsl_bank_t dac_reg;
    dsl_mode_t mode;
    logic      upo;
  } dsl_core_st_t;

  typedef struct packed {
    logic [DSL_WORD_W-1:0] shift;
    logic [4:0]            run;
  } dsl_link_st_t;

endpackage : dsl_pkg

// file: logic/dsl_chain_top.sv
// Serial command, shutdown lockout and chain output control for a quad converter
`timescale 1ns/1ps
`default_nettype none
module dsl_chain_top
  import dsl_pkg::*;
#(
  parameter int NUM_CH     = DSL_NUM_CH,
  parameter int FIFO_DEPTH = DSL_FIFO_DEPTH
) (
  input  wire logic      ref_clk,
  input  wire logic      sys_rst,
  input  wire logic      sclk,
  input  wire logic      cs_n,
  input  wire logic      din,
  input  wire logic      shutdown_lockout_n,
  input  wire logic      exec_hold,
  output logic           dout,
  output dsl_bank_t      dac_code,
  output logic           outputs_active,
  output logic           upo,
  output dsl_mode_t      dout_mode,
  output logic           cmd_ready
);

  if (NUM_CH != DSL_NUM_CH) begin : g_bad_ch
    $error("dsl_chain_top: two address bits serve exactly four channels");
  end

  // Link domain: shift register on the serial clock
  dsl_link_st_t link_q;
  dsl_link_st_t link_d;
  logic         dout_fall_q;
  logic         mode_l_raw;
  dsl_mode_t    mode_l;

  // Core domain
  dsl_core_st_t core_q;
  dsl_core_st_t core_d;
  logic         shutdown_q;
  logic         sd_set;
  logic         sd_clr;
  logic         sd_rst;
  logic [1:0]   pins_s;
  logic         cs_s;
  logic         lock_s;

  // FIFO handshake
  logic         fifo_in_ready;
  logic         fifo_out_valid;
  dsl_cmd_t     fifo_out_data;
  logic         pop;
  logic [3:0]   op;
  logic [1:0]   ch;
  logic [1:0]   ctrl;

  // ---------------- Link domain ----------------

  always_comb begin
    link_d = link_q;
    if (!cs_n) begin
      link_d.shift = {link_q.shift[DSL_WORD_W-2:0], din};
      if (link_q.run != DSL_LAG_RUN) begin
        link_d.run = link_q.run + 5'h01;
      end
    end else begin
      link_d.run = 5'h00;
    end
  end

  always_ff @(posedge sclk or posedge sys_rst) begin
    if (sys_rst) begin
      link_q <= '{shift: DSL_SHIFT_RST, run: 5'h00};
    end else begin
      link_q <= link_d;
    end
  end

  // half-cycle retimed copy for falling mode
  always_ff @(negedge sclk or posedge sys_rst) begin
    if (sys_rst) begin
      dout_fall_q <= 1'h0;
    end else begin
      dout_fall_q <= link_q.shift[DSL_WORD_W-1];
    end
  end

  dsl_sync #(
    .W       (1),
    .RST_VAL (1'h0)
  ) u_mode_sync (
    .clk (sclk),
    .rst (sys_rst),
    .d   (core_q.mode),
    .q   (mode_l_raw)
  );

  assign mode_l = dsl_mode_t'(mode_l_raw);

  assign dout = (mode_l == DSL_MODE_RISE) ? link_q.shift[DSL_WORD_W-1] : dout_fall_q;

  // ---------------- Core domain ----------------

  dsl_sync #(
    .W       (2),
    .RST_VAL (2'h3)
  ) u_pin_sync (
    .clk (ref_clk),
    .rst (sys_rst),
    .d   ({cs_n, shutdown_lockout_n}),
    .q   (pins_s)
  );

  assign cs_s   = pins_s[1];
  assign lock_s = pins_s[0];

  dsl_fifo #(
    .W     ($bits(dsl_cmd_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_cmd_fifo (
    .clk       (ref_clk),
    .rst       (sys_rst),
    .in_valid  (core_q.pend),
    .in_ready  (fifo_in_ready),
    .in_data   (core_q.word),
    .out_valid (fifo_out_valid),
    .out_ready (!exec_hold),
    .out_data  (fifo_out_data)
  );

  assign pop  = fifo_out_valid && !exec_hold;
  assign op   = {fifo_out_data.addr_bit_hi, fifo_out_data.addr_bit_lo,
                 fifo_out_data.ctrl_bit_hi, fifo_out_data.ctrl_bit_lo};
  assign ch   = {fifo_out_data.addr_bit_hi, fifo_out_data.addr_bit_lo};
  assign ctrl = {fifo_out_data.ctrl_bit_hi, fifo_out_data.ctrl_bit_lo};

  always_comb begin
    core_d         = core_q;
    core_d.cs_prev = cs_s;
    sd_set         = 1'b0;
    sd_clr         = 1'b0;
    // Word is stable once select is high and the serial clock idles
    if (cs_s && !core_q.cs_prev) begin
      core_d.pend = 1'b1;
      core_d.word = dsl_cmd_t'(link_q.shift);
    end else if (fifo_in_ready) begin
      core_d.pend = 1'b0;
    end
    if (pop) begin
      if (ctrl == DSL_CTRL_LOAD) begin
        core_d.in_reg[ch] = fifo_out_data.data;
      end else if (ctrl == DSL_CTRL_LOAD_UPD) begin
        core_d.in_reg[ch] = fifo_out_data.data;
        core_d.dac_reg    = core_d.in_reg;
        sd_clr            = 1'b1;
      end else begin
        case (op)
          DSL_OP_UPD_ALL: begin
            core_d.dac_reg = core_q.in_reg;
            sd_clr         = 1'b1;
          end
          DSL_OP_LOAD_ALL: begin
            for (int i = 0; i < DSL_NUM_CH; i++) begin
              core_d.in_reg[i]  = fifo_out_data.data;
              core_d.dac_reg[i] = fifo_out_data.data;
            end
            sd_clr = 1'b1;
          end
          DSL_OP_SHUTDOWN: begin
            sd_set = lock_s;
          end
          DSL_OP_UPO_LO: begin
            core_d.upo = 1'b0;
          end
          DSL_OP_UPO_HI: begin
            core_d.upo = 1'b1;
          end
          DSL_OP_MODE_RISE: begin
            core_d.mode    = DSL_MODE_RISE;
            core_d.dac_reg = core_q.in_reg;
            sd_clr         = 1'b1;
          end
          DSL_OP_MODE_FALL: begin
            core_d.mode    = DSL_MODE_FALL;
            core_d.dac_reg = core_q.in_reg;
            sd_clr         = 1'b1;
          end
          default: begin
            core_d.upo = core_q.upo;
          end
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      core_q <= '{cs_prev: 1'b1, pend: 1'b0, word: '0,
                  in_reg: {DSL_NUM_CH{DSL_ZERO_CODE}},
                  dac_reg: {DSL_NUM_CH{DSL_ZERO_CODE}},
                  mode: DSL_MODE_RST, upo: DSL_UPO_RST};
    end else begin
      core_q <= core_d;
    end
  end

  // lockout low clears shutdown without any clock
  assign sd_rst = sys_rst | ~shutdown_lockout_n;

  always_ff @(posedge ref_clk or posedge sd_rst) begin
    if (sd_rst) begin
      shutdown_q <= 1'b0;
    end else if (sd_set) begin
      shutdown_q <= 1'b1;
    end else if (sd_clr) begin
      shutdown_q <= 1'b0;
    end
  end

  assign dac_code       = core_q.dac_reg;
  assign outputs_active = !shutdown_q;
  assign upo            = core_q.upo;
  assign dout_mode      = core_q.mode;
  assign cmd_ready      = fifo_in_ready;

  // ---------------- Checks ----------------

  property p_lock_blocks;
    @(posedge ref_clk) disable iff (sys_rst)
      !lock_s |-> outputs_active;
  endproperty
  a_lock_blocks: assert property (p_lock_blocks)
    else $error("shutdown active while lockout low");

  property p_wake_restore;
    @(posedge ref_clk) disable iff (sys_rst)
      ($fell(lock_s) && !$past(pop) && !$past(pop, 2)) |-> (outputs_active && $stable(dac_code));
  endproperty
  a_wake_restore: assert property (p_wake_restore)
    else $error("wake did not restore previous outputs");

  property p_async_wake;
    @(posedge ref_clk) disable iff (sys_rst)
      !shutdown_lockout_n |-> !shutdown_q;
  endproperty
  a_async_wake: assert property (p_async_wake)
    else $error("lockout low did not wake at once");

  property p_chain_out;
    @(posedge sclk) disable iff (sys_rst)
      (link_q.run == DSL_LAG_RUN && !cs_n && !$past(cs_n)) |-> dout == $past(din, 16);
  endproperty
  a_chain_out: assert property (p_chain_out)
    else $error("chain output does not carry shifted input");

  property p_power_clear;
    @(posedge ref_clk) disable iff (sys_rst)
      $fell(sys_rst) |-> (dac_code == '0 && core_q.in_reg == '0 && !upo);
  endproperty
  a_power_clear: assert property (p_power_clear)
    else $error("registers not zero after power-up");

  property p_power_mode;
    @(posedge ref_clk) disable iff (sys_rst)
      $fell(sys_rst) |-> (dout_mode == DSL_MODE_FALL) ##1 (dout_mode == DSL_MODE_FALL);
  endproperty
  a_power_mode: assert property (p_power_mode)
    else $error("power-up mode not falling edge");

  property p_word_fields;
    @(posedge ref_clk) disable iff (sys_rst)
      (pop && ctrl == DSL_CTRL_LOAD) |=> core_q.in_reg[$past(ch)] == $past(fifo_out_data.data);
  endproperty
  a_word_fields: assert property (p_word_fields)
    else $error("input register load mismatched word fields");

  property p_sd_gate;
    @(posedge ref_clk) disable iff (sys_rst)
      (pop && op == DSL_OP_SHUTDOWN && lock_s) ##1 shutdown_lockout_n |-> !outputs_active;
  endproperty
  a_sd_gate: assert property (p_sd_gate)
    else $error("shutdown command with lockout high had no effect");

  property p_sd_keep;
    @(posedge ref_clk) disable iff (sys_rst)
      (!outputs_active && pop && ctrl == DSL_CTRL_LOAD)
        |=> ($stable(dac_code) && core_q.in_reg[$past(ch)] == $past(fifo_out_data.data));
  endproperty
  a_sd_keep: assert property (p_sd_keep)
    else $error("load during shutdown disturbed outputs");

  property p_lag_mode;
    @(negedge sclk) disable iff (sys_rst)
      (mode_l == $past(mode_l) && link_q.run == DSL_LAG_RUN
        && $past(link_q.run) == DSL_LAG_RUN) |->
        dout == ((mode_l == DSL_MODE_RISE) ? $past(din, 15) : $past(din, 16));
  endproperty
  a_lag_mode: assert property (p_lag_mode)
    else $error("chain output edge timing wrong for mode");

  c_shutdown_wake: cover property (@(posedge ref_clk) disable iff (sys_rst)
    shutdown_q ##[1:50] !shutdown_q);
  c_mode_rise: cover property (@(posedge ref_clk) disable iff (sys_rst)
    $rose(dout_mode));
  c_load_all: cover property (@(posedge ref_clk) disable iff (sys_rst)
    pop && op == DSL_OP_LOAD_ALL);
  c_fifo_full: cover property (@(posedge ref_clk) disable iff (sys_rst)
    core_q.pend && !fifo_in_ready);

endmodule : dsl_chain_top
`default_nettype wire

// file: logic/dsl_fifo.sv
// Command word FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module dsl_fifo #(
  parameter int W     = 16,
  parameter int DEPTH = 16
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("dsl_fifo: DEPTH must be a power of two, at least 2");
  end

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW:0]             wp;
    logic [AW:0]             rp;
  } dsl_fifo_st_t;

  dsl_fifo_st_t st_q;
  dsl_fifo_st_t st_d;
  logic         full;
  logic         empty;

  assign full      = (st_q.wp[AW] != st_q.rp[AW]) && (st_q.wp[AW-1:0] == st_q.rp[AW-1:0]);
  assign empty     = (st_q.wp == st_q.rp);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = st_q.mem[st_q.rp[AW-1:0]];

  always_comb begin
    st_d = st_q;
    if (in_valid && !full) begin
      st_d.mem[st_q.wp[AW-1:0]] = in_data;
      st_d.wp                   = st_q.wp + 1'b1;
    end
    if (out_ready && !empty) begin
      st_d.rp = st_q.rp + 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

endmodule : dsl_fifo
`default_nettype wire

// file: logic/dsl_sync.sv
// Two-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none
module dsl_sync #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } dsl_sync_st_t;

  dsl_sync_st_t st_q;
  dsl_sync_st_t st_d;

  always_comb begin
    st_d.s1 = d;
    st_d.s2 = st_q.s1;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= {RST_VAL, RST_VAL};
    end else begin
      st_q <= st_d;
    end
  end

  assign q = st_q.s2;

endmodule : dsl_sync
`default_nettype wire

// file: testbench/dsl_chain_tb_top.sv
// Self-checking bench for lockout, serial commands and chain output
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin \
  compares++; \
  if ((g) !== (e)) begin \
    err_total++; \
    $display("[FAIL] %s exp=%h got=%h", nm, e, g); \
  end \
end
module dsl_chain_tb_top
  import dsl_pkg::*;
;
  logic        ref_clk;
  logic        sys_rst;
  logic        lockout_n;
  logic        exec_hold;
  logic        sclk;
  logic        cs_n;
  logic        din;
  logic        dout;
  logic        act;
  logic        upo;
  logic        cmd_ready;
  logic [31:0] cap;
  dsl_bank_t   dac_code;
  dsl_mode_t   dout_mode;
  dsl_bank_t   exp_in;
  dsl_bank_t   exp_dac;
  logic        exp_upo;
  logic        exp_act;
  dsl_mode_t   exp_mode;
  logic [15:0] word_a;
  int          err_total;
  int          compares;
  integer      seed = 32'h96F54E74;
  logic [3:0]  codes [15] = '{4'h1, 4'h5, 4'h9, 4'hD, 4'h3, 4'h7, 4'hB, 4'hF,
                              4'h4, 4'h8, 4'h2, 4'h6, 4'hE, 4'hA, 4'h0};

  dsl_chain_top uut (
    .ref_clk            (ref_clk),
    .sys_rst            (sys_rst),
    .sclk               (sclk),
    .cs_n               (cs_n),
    .din                (din),
    .shutdown_lockout_n (lockout_n),
    .exec_hold          (exec_hold),
    .dout               (dout),
    .dac_code           (dac_code),
    .outputs_active     (act),
    .upo                (upo),
    .dout_mode          (dout_mode),
    .cmd_ready          (cmd_ready)
  );

  dsl_host_model host (
    .sclk (sclk),
    .cs_n (cs_n),
    .din  (din),
    .dout (dout),
    .cap  (cap)
  );

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  function automatic void model_reset();
    exp_in   = '0;
    exp_dac  = '0;
    exp_upo  = 1'b0;
    exp_act  = 1'b1;
    exp_mode = DSL_MODE_FALL;
  endfunction : model_reset

  // Expected register effect of one command word
  function automatic void apply(input logic [15:0] w);
    if (w[12]) begin
      exp_in[w[15:14]] = w[11:0];
      if (w[13]) begin
        exp_dac = exp_in;
        exp_act = 1'b1;
      end
    end else begin
      case (w[15:12])
        DSL_OP_UPD_ALL, DSL_OP_MODE_RISE, DSL_OP_MODE_FALL: begin
          if (w[13]) begin
            exp_mode = dsl_mode_t'(w[14]);
          end
          exp_dac = exp_in;
          exp_act = 1'b1;
        end
        DSL_OP_LOAD_ALL: begin
          exp_in  = {4{w[11:0]}};
          exp_dac = exp_in;
          exp_act = 1'b1;
        end
        DSL_OP_SHUTDOWN: begin
          if (lockout_n) begin
            exp_act = 1'b0;
          end
        end
        DSL_OP_UPO_LO: exp_upo = 1'b0;
        DSL_OP_UPO_HI: exp_upo = 1'b1;
        default: ;
      endcase
    end
  endfunction : apply

  task automatic cmd(input logic [15:0] w);
    host.send({16'h0000, w}, 16);
    apply(w);
    repeat (10) @(posedge ref_clk);
  endtask : cmd

  task automatic check_all();
    `CHK("dac_code", exp_dac, dac_code)
    `CHK("upo", exp_upo, upo)
    `CHK("dout_mode", exp_mode, dout_mode)
    `CHK("outputs_active", exp_act, act)
  endtask : check_all

  task automatic do_reset();
    sys_rst <= 1'b1;
    repeat (6) @(posedge ref_clk);
    sys_rst <= 1'b0;
    model_reset();
    repeat (3) @(posedge ref_clk);
  endtask : do_reset

  task automatic final_report();
    if (err_total == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : final_report

  initial begin
    #600000;
    err_total++;
    final_report();
  end

  initial begin
    // Low at start so do_reset gives every flop a real reset edge
    sys_rst   = 1'b0;
    lockout_n = 1'b1;
    exec_hold = 1'b0;
    err_total = 0;
    compares  = 0;
    @(posedge ref_clk);
    do_reset();
    check_all();
    `CHK("cmd_ready", 1'b1, cmd_ready)
    foreach (codes[i]) begin
      cmd({codes[i], 12'($random(seed))});
      check_all();
    end
    repeat (8) begin
      cmd({codes[$unsigned($random(seed)) % 15], 12'($random(seed))});
      check_all();
    end
    cmd({DSL_OP_SHUTDOWN, 12'h000});
    check_all();
    cmd({2'($random(seed)), 2'h1, 12'($random(seed))});
    check_all();
    lockout_n <= 1'b0;
    #1;
    exp_act = 1'b1;
    check_all();
    cmd({DSL_OP_SHUTDOWN, 12'h000});
    check_all();
    lockout_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    // Rising mode first, then back to falling
    for (int m = 0; m < 2; m++) begin
      cmd({(m == 0) ? DSL_OP_MODE_RISE : DSL_OP_MODE_FALL, 12'h000});
      word_a = 16'($random(seed));
      host.send({word_a, DSL_OP_NOP, 12'($random(seed))}, 32);
      repeat (10) @(posedge ref_clk);
      `CHK("dout_chain", (m == 0) ? {word_a[14:0], 1'b0} : word_a, cap[15:0])
      check_all();
    end
    exec_hold <= 1'b1;
    repeat (DSL_FIFO_DEPTH) cmd({2'($random(seed)), 2'h1, 12'($random(seed))});
    `CHK("cmd_ready_full", 1'b0, cmd_ready)
    exec_hold <= 1'b0;
    repeat (40) @(posedge ref_clk);
    `CHK("cmd_ready_drained", 1'b1, cmd_ready)
    cmd({DSL_OP_UPD_ALL, 12'h000});
    check_all();
    do_reset();
    check_all();
    final_report();
  end
endmodule : dsl_chain_tb_top
`default_nettype wire

// file: testbench/dsl_host_model.sv
// Host serial controller model driving the converter link
`timescale 1ns/1ps
`default_nettype none
module dsl_host_model (
  output logic        sclk,
  output logic        cs_n,
  output logic        din,
  input  wire logic   dout,
  output logic [31:0] cap
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    din  = 1'b0;
    cap  = '0;
  end
  // own select, one frame at a time
  // sent MSB first, clock idle low
  task automatic send(input logic [31:0] bits, input int n);
    cs_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      din = bits[i];
      #62.5 sclk = 1'b1;
      #62.5 cap = {cap[30:0], dout};
      sclk = 1'b0;
    end
    #62.5 cs_n = 1'b1;
    din = ~din;
    #100;
  endtask : send
endmodule : dsl_host_model
`default_nettype wire
